// ### hdl/icy_core.sv
// Purpose: 8-bit core that executes one instruction per four-clock cycle
// Assumes: Program and data memory answer combinationally to the address
// Notes: Extra cycles are inserted as bubbles or as a table fetch
//
// Contract
// - Every instruction cycle lasts exactly four system clocks.
// - Branch, invoke, exits and table reads take two instruction cycles.
// - Writing the program counter low byte jumps and costs one extra cycle, except from a table read.
// - A skip costs one cycle, plus one more when the skip is taken.
// - Addition carries above 255; subtraction signals borrow below zero.
// - Add_one and subtract_one change by one, into memory or accumulator.
// - AND, OR, XOR and complement set zero flag on a zero result.
// - Rotates shift one bit; carry variants pass the leaving bit through carry.
// - Bit set and clear change only one bit via internal read-modify-write.
// - Subroutine_exit resumes after the invoke; unconditional_branch saves nothing.
// - Conditional branches test a memory value or bit and skip or continue.
// - Table reads fetch program memory data and deliver it to data memory.
// - Add and subtract variants update zero, carry, auxiliary carry, overflow.
`include "icy_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module icy_core (
    input wire logic clk,
    input wire logic rst_b,
    output logic [10:0] prog_addr,
    input wire logic [15:0] prog_data,
    output logic [7:0] dmem_addr,
    output logic [7:0] dmem_wdata,
    output logic dmem_we,
    input wire logic [7:0] dmem_rdata,
    output logic [7:0] acc,
    output logic [3:0] flags,
    output logic cycle_start
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [1:0] phase_reg;
    icy_pkg::icy_mode_t mode_reg;
    icy_pkg::icy_mode_t mode_next;
    logic [15:0] instr_reg;
    logic [7:0] tbl_data_reg;
    logic [10:0] pc_reg;
    logic [10:0] pc_next;
    logic [10:0] pc_inc;
    logic [7:0] acc_reg;
    logic z_reg, c_reg, ac_reg, ov_reg;
    logic [10:0] stack_mem [0:`ICY_STACK_DEPTH-1];
    logic [2:0] sp_reg;
    logic [2:0] sp_down;

    // Decode and datapath results
    icy_pkg::icy_op_t op;
    logic [7:0] m_val;
    logic [7:0] imm;
    logic [2:0] bidx;
    logic [7:0] b_op;
    logic [7:0] bx;
    logic sub_op;
    logic cin;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] res;
    logic wr_acc, wr_mem, skip;
    logic upd_z, upd_arith, upd_c;
    logic c_new;
    logic push, pop;
    logic pc_low_write;
    logic exec_run;

    assign pc_inc = pc_reg + 11'h001;
    assign sp_down = sp_reg - 3'h1;
    assign exec_run = (phase_reg == `ICY_PH_EXEC) && (mode_reg == icy_pkg::ICY_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Phase counter: four clocks per instruction cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= `ICY_PH_FETCH;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // Marks the first clock of each instruction cycle but the first after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_start <= 1'b0;
        end else begin
            cycle_start <= (phase_reg == `ICY_PH_NEXT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath for the instruction held in instr_reg
    always_comb begin
        op = icy_pkg::icy_op_t'(instr_reg[`ICY_OP_MSB:`ICY_OP_LSB]);
        m_val = dmem_rdata;
        imm = instr_reg[`ICY_OPND_MSB:0];
        bidx = instr_reg[`ICY_BIT_MSB:`ICY_BIT_LSB];
        b_op = m_val;
        sub_op = 1'b0;
        cin = 1'b0;
        // Operand selection for the shared adder
        unique case (op)
            icy_pkg::ICY_ADD_A_X: b_op = imm;
            icy_pkg::ICY_ADC_A_M: cin = c_reg;
            icy_pkg::ICY_SUB_A_M, icy_pkg::ICY_SUB_M: begin
                sub_op = 1'b1;
                cin = 1'b1;
            end
            icy_pkg::ICY_SUB_A_X: begin
                b_op = imm;
                sub_op = 1'b1;
                cin = 1'b1;
            end
            icy_pkg::ICY_SBC_A_M: begin
                sub_op = 1'b1;
                cin = c_reg;
            end
            default: b_op = m_val;
        endcase
        bx = sub_op ? ~b_op : b_op;
        // Carry out means no borrow for subtraction
        sum9 = {1'b0, acc_reg} + {1'b0, bx} + {8'h00, cin};
        nib5 = {1'b0, acc_reg[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        res = 8'h00;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        skip = 1'b0;
        upd_z = 1'b0;
        upd_arith = 1'b0;
        upd_c = 1'b0;
        c_new = c_reg;
        push = 1'b0;
        pop = 1'b0;
        pc_next = pc_inc;
        mode_next = icy_pkg::ICY_RUN;
        unique case (op)
            icy_pkg::ICY_NOP: res = 8'h00;
            icy_pkg::ICY_MOV_A_M: begin
                res = m_val;
                wr_acc = 1'b1;
            end
            icy_pkg::ICY_MOV_M_A: begin
                res = acc_reg;
                wr_mem = 1'b1;
            end
            icy_pkg::ICY_MOV_A_X: begin
                res = imm;
                wr_acc = 1'b1;
            end
            icy_pkg::ICY_ADD_A_M, icy_pkg::ICY_ADD_A_X, icy_pkg::ICY_ADC_A_M,
            icy_pkg::ICY_SUB_A_M, icy_pkg::ICY_SUB_A_X, icy_pkg::ICY_SBC_A_M: begin
                res = sum9[7:0];
                wr_acc = 1'b1;
                upd_arith = 1'b1;
            end
            icy_pkg::ICY_ADD_M, icy_pkg::ICY_SUB_M: begin
                res = sum9[7:0];
                wr_mem = 1'b1;
                upd_arith = 1'b1;
            end
            icy_pkg::ICY_AND_A_M: begin
                res = acc_reg & m_val;
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            icy_pkg::ICY_OR_A_M: begin
                res = acc_reg | m_val;
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            icy_pkg::ICY_XOR_A_M: begin
                res = acc_reg ^ m_val;
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            icy_pkg::ICY_CPL_M, icy_pkg::ICY_CPL_A: begin
                res = ~m_val;
                wr_mem = (op == icy_pkg::ICY_CPL_M);
                wr_acc = (op == icy_pkg::ICY_CPL_A);
                upd_z = 1'b1;
            end
            icy_pkg::ICY_ADD_ONE_M, icy_pkg::ICY_ADD_ONE_A: begin
                res = m_val + 8'h01;
                wr_mem = (op == icy_pkg::ICY_ADD_ONE_M);
                wr_acc = (op == icy_pkg::ICY_ADD_ONE_A);
                upd_z = 1'b1;
            end
            icy_pkg::ICY_SUBTRACT_ONE_M, icy_pkg::ICY_SUBTRACT_ONE_A: begin
                res = m_val - 8'h01;
                wr_mem = (op == icy_pkg::ICY_SUBTRACT_ONE_M);
                wr_acc = (op == icy_pkg::ICY_SUBTRACT_ONE_A);
                upd_z = 1'b1;
            end
            icy_pkg::ICY_ROTATE_M, icy_pkg::ICY_ROTATE_A: begin
                wr_mem = (op == icy_pkg::ICY_ROTATE_M);
                wr_acc = (op == icy_pkg::ICY_ROTATE_A);
                upd_c = instr_reg[`ICY_ROT_CARRY_BIT];
                if (instr_reg[`ICY_ROT_LEFT_BIT]) begin
                    // Left: bit 7 leaves, carry or bit 7 enters bit 0
                    res = {m_val[6:0], upd_c ? c_reg : m_val[7]};
                    c_new = m_val[7];
                end else begin
                    // Right: bit 0 leaves, carry or bit 0 enters bit 7
                    res = {upd_c ? c_reg : m_val[0], m_val[7:1]};
                    c_new = m_val[0];
                end
            end
            icy_pkg::ICY_BIT_SET: begin
                res = m_val | (8'h01 << bidx);
                wr_mem = 1'b1;
            end
            icy_pkg::ICY_BIT_CLEAR: begin
                res = m_val & ~(8'h01 << bidx);
                wr_mem = 1'b1;
            end
            icy_pkg::ICY_SKIP_ZERO: skip = (m_val == 8'h00);
            icy_pkg::ICY_SKIP_BIT_ZERO: skip = !m_val[bidx];
            icy_pkg::ICY_SKIP_BIT_ONE: skip = m_val[bidx];
            icy_pkg::ICY_UNCONDITIONAL_BRANCH: begin
                pc_next = instr_reg[`ICY_TGT_MSB:0];
                mode_next = icy_pkg::ICY_BUBBLE;
            end
            icy_pkg::ICY_SUBROUTINE_INVOKE: begin
                push = 1'b1;
                pc_next = instr_reg[`ICY_TGT_MSB:0];
                mode_next = icy_pkg::ICY_BUBBLE;
            end
            icy_pkg::ICY_SUBROUTINE_EXIT: begin
                pop = 1'b1;
                pc_next = stack_mem[sp_down];
                mode_next = icy_pkg::ICY_BUBBLE;
            end
            icy_pkg::ICY_TABLE_READ: mode_next = icy_pkg::ICY_TABLE;
        endcase
        // Memory writes to the low program counter byte, other than table writes, become jumps
        pc_low_write = wr_mem && (dmem_addr == `ICY_PC_LOW_ADDR);
        if (pc_low_write) begin
            pc_next = {pc_reg[10:8], res};
            mode_next = icy_pkg::ICY_BUBBLE;
        end
        if (skip) begin
            pc_next = pc_reg + 11'h002;
            mode_next = icy_pkg::ICY_BUBBLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction and table data capture in the fetch phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_reg <= 16'h0000;
            tbl_data_reg <= 8'h00;
        end else if (phase_reg == `ICY_PH_FETCH) begin
            if (mode_reg == icy_pkg::ICY_TABLE) begin
                tbl_data_reg <= prog_data[7:0];
            end else if (mode_reg == icy_pkg::ICY_RUN) begin
                instr_reg <= prog_data;
            end
        end
    end

    // Mode of the next instruction cycle: run, bubble or table fetch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= icy_pkg::ICY_RUN;
        end else if (phase_reg == `ICY_PH_NEXT) begin
            mode_reg <= (mode_reg == icy_pkg::ICY_RUN) ? mode_next : icy_pkg::ICY_RUN;
        end
    end

    // Program counter advances once per executed instruction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= `ICY_PC_RESET;
        end else if (exec_run) begin
            pc_reg <= pc_next;
        end
    end

    // Fetch address: next instruction, or table location in the last page
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_addr <= `ICY_PC_RESET;
        end else if (phase_reg == `ICY_PH_NEXT) begin
            if (mode_reg == icy_pkg::ICY_RUN && mode_next == icy_pkg::ICY_TABLE) begin
                prog_addr <= {`ICY_TABLE_PAGE, acc_reg};
            end else begin
                prog_addr <= pc_reg;
            end
        end
    end

    // Hardware stack of return addresses
    always_ff @(posedge clk) begin
        if (exec_run && push) begin
            stack_mem[sp_reg] <= pc_inc;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg <= `ICY_SP_RESET;
        end else if (exec_run && push) begin
            sp_reg <= sp_reg + 3'h1;
        end else if (exec_run && pop) begin
            sp_reg <= sp_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data memory: address in decode, write strobe for one clock after execute
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dmem_addr <= 8'h00;
        end else if (phase_reg == `ICY_PH_DECODE) begin
            dmem_addr <= instr_reg[`ICY_OPND_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dmem_we <= 1'b0;
            dmem_wdata <= 8'h00;
        end else if (phase_reg == `ICY_PH_EXEC) begin
            if (mode_reg == icy_pkg::ICY_TABLE) begin
                dmem_we <= 1'b1;
                dmem_wdata <= tbl_data_reg;
            end else begin
                // Whole byte rewritten after internal modify
                dmem_we <= exec_run && wr_mem && !pc_low_write;
                dmem_wdata <= res;
            end
        end else begin
            dmem_we <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator and flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= 8'h00;
        end else if (exec_run && wr_acc) begin
            acc_reg <= res;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            z_reg <= 1'b0;
            c_reg <= 1'b0;
            ac_reg <= 1'b0;
            ov_reg <= 1'b0;
        end else if (exec_run) begin
            if (upd_z || upd_arith) begin
                z_reg <= (res == 8'h00);
            end
            if (upd_arith) begin
                c_reg <= sum9[8];
                ac_reg <= nib5[4];
                ov_reg <= (acc_reg[7] == bx[7]) && (sum9[7] != acc_reg[7]);
            end else if (upd_c) begin
                c_reg <= c_new;
            end
        end
    end

    assign acc = acc_reg;
    assign flags = {ov_reg, ac_reg, c_reg, z_reg};

endmodule

`default_nettype wire

// ### hdl/icy_consts.svh
// Purpose: Constants of the instruction cycle timing core
// Assumes: Included by its bare name
// Notes: Offsets, field positions, reset values and phase codes
`ifndef ICY_CONSTS_SVH
`define ICY_CONSTS_SVH

// Clocks per instruction cycle and the phase codes inside it
`define ICY_CLKS_PER_CYCLE 4
`define ICY_PH_FETCH 2'h0
`define ICY_PH_DECODE 2'h1
`define ICY_PH_EXEC 2'h2
`define ICY_PH_NEXT 2'h3

// Instruction word fields
`define ICY_OP_MSB 15
`define ICY_OP_LSB 11
`define ICY_BIT_MSB 10
`define ICY_BIT_LSB 8
`define ICY_ROT_LEFT_BIT 8
`define ICY_ROT_CARRY_BIT 9
`define ICY_EXIT_INT_BIT 8
`define ICY_OPND_MSB 7
`define ICY_TGT_MSB 10

// Data memory address that holds the program counter low byte
`define ICY_PC_LOW_ADDR 8'h06

// Table reads use the last page of program memory
`define ICY_TABLE_PAGE 3'h7

// Reset values and stack depth
`define ICY_PC_RESET 11'h000
`define ICY_SP_RESET 3'h0
`define ICY_STACK_DEPTH 8

`endif

// ### hdl/icy_pkg.sv
// Purpose: Types of the instruction cycle timing core
// Assumes: Opcode field is five bits, codes follow declaration order
// Notes: All 32 codes are legal
`default_nettype none
package icy_pkg;

    typedef enum logic [4:0] {
        ICY_NOP, ICY_MOV_A_M, ICY_MOV_M_A, ICY_MOV_A_X,
        ICY_ADD_A_M, ICY_ADD_M, ICY_ADD_A_X, ICY_ADC_A_M,
        ICY_SUB_A_M, ICY_SUB_M, ICY_SUB_A_X, ICY_SBC_A_M,
        ICY_AND_A_M, ICY_OR_A_M, ICY_XOR_A_M, ICY_CPL_M,
        ICY_CPL_A, ICY_ADD_ONE_M, ICY_ADD_ONE_A, ICY_SUBTRACT_ONE_M,
        ICY_SUBTRACT_ONE_A, ICY_ROTATE_M, ICY_ROTATE_A, ICY_BIT_SET,
        ICY_BIT_CLEAR, ICY_SKIP_ZERO, ICY_SKIP_BIT_ZERO, ICY_SKIP_BIT_ONE,
        ICY_UNCONDITIONAL_BRANCH, ICY_SUBROUTINE_INVOKE, ICY_SUBROUTINE_EXIT,
        ICY_TABLE_READ
    } icy_op_t;

    typedef enum logic [1:0] {
        ICY_RUN, ICY_BUBBLE, ICY_TABLE
    } icy_mode_t;

endpackage
`default_nettype wire

// ### verif/icy_mem_model.sv
// Purpose: Program and data memory on the far side of the core
// Assumes: Reads answer at once to the address
// Notes: Unwritten data bytes hold a fixed pattern, their address XOR 5A (zero at 5A)
`timescale 1ns/1ps
`default_nettype none
module icy_mem_model (
    input wire logic clk,
    input wire logic [10:0] prog_addr,
    output logic [15:0] prog_data,
    input wire logic [7:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we,
    output logic [7:0] dmem_rdata
);
    logic [15:0] pm [2048];
    logic [7:0] dm [256];
    ////////////////////////////////////////
    // Fill both memories so that no read returns an unknown
    initial begin
        for (int i = 0; i < 2048; i++) begin
            pm[i] = 16'h0000;
        end
        for (int i = 0; i < 256; i++) begin
            dm[i] = 8'(i) ^ 8'h5A;
        end
    end
    // Combinational reads
    assign prog_data = pm[prog_addr];
    assign dmem_rdata = dm[dmem_addr];
    // Byte write taken at the end of the strobe clock
    always @(posedge clk) begin
        if (dmem_we) begin
            dm[dmem_addr] <= dmem_wdata;
        end
    end
endmodule
`default_nettype wire

// ### verif/icy_core_monitor.sv
// Purpose: Port timing checks for the instruction cycle core
// Assumes: cycle_start marks phase 0 of every instruction cycle but the first after reset
// Notes: Bound to every core instance
`timescale 1ns/1ps
`default_nettype none
`include "icy_consts.svh"
module icy_core_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [10:0] prog_addr,
    input wire logic [15:0] prog_data,
    input wire logic [7:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we,
    input wire logic [7:0] dmem_rdata,
    input wire logic [7:0] acc,
    input wire logic [3:0] flags,
    input wire logic cycle_start
);
    default clocking dck @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    property p_cycle_len;
        cycle_start |=> !cycle_start [*3] ##1 cycle_start;
    endproperty
    a_cycle_len: assert property (p_cycle_len)
        else $error("cycle_start period is not four clocks");
    property p_we_phase;
        dmem_we |=> cycle_start;
    endproperty
    a_we_phase: assert property (p_we_phase)
        else $error("write strobe not in the last phase");
    property p_we_single;
        dmem_we |=> !dmem_we [*3];
    endproperty
    a_we_single: assert property (p_we_single)
        else $error("more than one write in a cycle");
    property p_no_pc_low_store;
        dmem_we |-> dmem_addr != `ICY_PC_LOW_ADDR;
    endproperty
    a_no_pc_low_store: assert property (p_no_pc_low_store)
        else $error("low counter byte written to data memory");
    property p_fetch_hold;
        !cycle_start |-> $stable(prog_addr);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold)
        else $error("fetch address moved inside a cycle");
    property p_addr_hold;
        dmem_we |-> $stable(dmem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("data address moved under the write");
    property p_wdata_hold;
        dmem_we |=> $stable(dmem_wdata) [*3];
    endproperty
    a_wdata_hold: assert property (p_wdata_hold)
        else $error("write data did not stand");
    property p_state_phase;
        !$stable({acc, flags}) |=> cycle_start;
    endproperty
    a_state_phase: assert property (p_state_phase)
        else $error("accumulator or flags changed off the execute phase");
endmodule
bind icy_core icy_core_monitor icy_core_monitor_i (.clk(clk), .rst_b(rst_b),
    .prog_addr(prog_addr), .prog_data(prog_data), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_rdata(dmem_rdata),
    .acc(acc), .flags(flags), .cycle_start(cycle_start));
`default_nettype wire

// ### verif/icy_core_tb_top.sv
// Purpose: Self-checking bench for the instruction cycle core
// Assumes: The whole program is laid out during reset
// Notes: Each data write is compared with the oldest expected write
`timescale 1ns/1ps
`default_nettype none
`include "icy_consts.svh"
module icy_core_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [10:0] prog_addr;
    logic [15:0] prog_data;
    logic [7:0] dmem_addr, dmem_wdata, dmem_rdata, acc, a;
    logic dmem_we, cycle_start;
    logic [3:0] flags, fl;
    logic [59:0] exq [$];
    logic [59:0] got, want;
    int n_mismatch = 0;
    int check_count = 0;
    int ncyc = 0;
    int seed = 32'h6220;
    int pc = 0;
    int cyc = 0;
    int cg [5];
    icy_pkg::icy_op_t sop [3] = '{icy_pkg::ICY_SKIP_ZERO, icy_pkg::ICY_SKIP_BIT_ZERO,
        icy_pkg::ICY_SKIP_BIT_ONE};
    icy_pkg::icy_op_t aop [8] = '{icy_pkg::ICY_ADD_A_M, icy_pkg::ICY_ADC_A_M,
        icy_pkg::ICY_SUB_A_M, icy_pkg::ICY_SBC_A_M, icy_pkg::ICY_ADD_A_X,
        icy_pkg::ICY_SUB_A_X, icy_pkg::ICY_ADD_M, icy_pkg::ICY_SUB_M};
    icy_pkg::icy_op_t zop [9] = '{icy_pkg::ICY_AND_A_M, icy_pkg::ICY_OR_A_M,
        icy_pkg::ICY_XOR_A_M, icy_pkg::ICY_CPL_M, icy_pkg::ICY_CPL_A, icy_pkg::ICY_ADD_ONE_M,
        icy_pkg::ICY_ADD_ONE_A, icy_pkg::ICY_SUBTRACT_ONE_M, icy_pkg::ICY_SUBTRACT_ONE_A};
    icy_core icy_core_i (.clk, .rst_b, .prog_addr, .prog_data, .dmem_addr, .dmem_wdata,
        .dmem_we, .dmem_rdata, .acc, .flags, .cycle_start);
    icy_mem_model icy_mem_model_i (.clk, .prog_addr, .prog_data, .dmem_addr, .dmem_wdata,
        .dmem_we, .dmem_rdata);
    ////////////////////////////////////////
    // Clock
    always #4 clk = ~clk;
    // Program building and expectation notes
    task automatic put(input icy_pkg::icy_op_t op, input logic [10:0] f);
        icy_mem_model_i.pm[pc] = {op, f};
        pc++;
    endtask
    task automatic pz;
        put(icy_pkg::ICY_MOV_M_A, 11'h0EE);
    endtask
    task automatic ex(input logic [7:0] ad, input logic [7:0] d, input int n);
        exq.push_back({ad, d, a, fl, 32'(cyc + n - 1)}); // First cycle after reset has no marker
    endtask
    task automatic st(input logic [7:0] ad);
        put(icy_pkg::ICY_MOV_M_A, {3'h0, ad});
        ex(ad, a, 1);
        cyc++;
    endtask
    task automatic lda(input logic [7:0] v);
        put(icy_pkg::ICY_MOV_A_X, {3'h0, v});
        a = v;
        cyc++;
    endtask
    // Sum with flags {ov, ac, c, z} above the result
    function automatic logic [11:0] addf(input logic [7:0] x, input logic [7:0] y,
        input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        return {(x[7] == y[7]) && (s[7] != x[7]), h[4], s[8], s[7:0] == 8'h00, s[7:0]};
    endfunction
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wq(input int n);
        for (int t = 0; t < 3000 && exq.size() > n; t++) begin
            @(posedge clk);
        end
        if (exq.size() > n) begin
            n_mismatch++;
            $display("mismatch at %0t: left %0h want %0h", $time, exq.size(), n);
            stop_test;
        end
    endtask
    ////////////////////////////////////////
    // Count cycles and compare each data write with the oldest note
    always @(posedge clk) begin
        if (cycle_start === 1'b1) ncyc++;
        if (dmem_we === 1'b1) begin
            got = {dmem_addr, dmem_wdata, acc, flags, 32'(ncyc)};
            want = (exq.size() > 0) ? exq.pop_front() : '1;
            check_count++;
            if (got !== want) begin
                n_mismatch++;
                $display("mismatch at %0t: got %0h want %0h", $time, got, want);
            end
        end
    end
    // Stimulus
    initial begin
        int k, sv, tot;
        logic [7:0] m, v, ad, r8;
        logic [11:0] r;
        logic [15:0] w;
        logic [2:0] b;
        logic sb, lt, th;
        a = 8'h00;
        fl = 4'h0;
        @(posedge clk);
        for (k = 0; k < 6; k++) begin
            b = 3'(k + 2);
            m = 8'($random(seed));
            if (k < 2) m = k[0] ? 8'h00 : (m | 8'h01);
            else m[b] = k[0] ^ (k < 4);
            ad = 8'(8'hA0 + k);
            icy_mem_model_i.dm[ad] = m;
            put(sop[k / 2], {b, ad});
            if (k[0]) pz;
            cyc += k[0] ? 2 : 1;
            st(8'(8'hB0 + k));
        end
        put(icy_pkg::ICY_UNCONDITIONAL_BRANCH, 11'(pc + 3));
        pz;
        pz;
        cyc += 2;
        st(8'hC0);
        lda(8'(pc + 4));
        put(icy_pkg::ICY_MOV_M_A, {3'h0, `ICY_PC_LOW_ADDR});
        pz;
        pz;
        cyc += 2;
        st(8'hC1);
        for (k = 0; k < 2; k++) begin
            sv = pc;
            pc = 11'h600 + 4 * k;
            lda(8'(8'hD0 + k));
            put(icy_pkg::ICY_SUBROUTINE_EXIT, 11'(k << 8));
            pc = sv;
            put(icy_pkg::ICY_SUBROUTINE_INVOKE, 11'(11'h600 + 4 * k));
            cyc += 4;
            st(8'(8'hC2 + k));
        end
        for (k = 0; k < 2; k++) begin
            lda({k[0], 7'($random(seed))}); // Top bit keeps the two table words apart
            w = 16'($random(seed));
            icy_mem_model_i.pm[{`ICY_TABLE_PAGE, a}] = w;
            put(icy_pkg::ICY_TABLE_READ, {3'h0, 8'(8'hC8 + k)});
            ex(8'(8'hC8 + k), w[7:0], 2);
            cyc += 2;
        end
        cg[0] = exq.size();
        for (k = 0; k < 8; k++) begin
            m = (k == 0) ? 8'h01 : 8'($random(seed));
            v = (k == 0) ? 8'hFF : 8'($random(seed));
            ad = 8'(8'h20 + k);
            icy_mem_model_i.dm[ad] = m;
            lda(v);
            sb = k inside {2, 3, 5, 7};
            r = addf(v, sb ? ~m : m, (k == 1 || k == 3) ? fl[1] : sb);
            fl = r[11:8];
            put(aop[k], {3'h0, (k == 4 || k == 5) ? m : ad});
            if (k > 5) ex(ad, r[7:0], 1);
            else a = r[7:0];
            cyc++;
            if (k <= 5) st(8'(8'h40 + k));
        end
        cg[1] = exq.size();
        for (k = 0; k < 9; k++) begin
            v = 8'($random(seed));
            m = (k == 0) ? ~v : (k == 6) ? 8'hFF : (k == 7) ? 8'h01 : 8'($random(seed));
            ad = 8'(8'h50 + k);
            icy_mem_model_i.dm[ad] = m;
            lda(v);
            case (k)
                0: r8 = v & m;
                1: r8 = v | m;
                2: r8 = v ^ m;
                3, 4: r8 = ~m;
                5, 6: r8 = m + 8'h01;
                default: r8 = m - 8'h01;
            endcase
            fl[0] = (r8 == 8'h00);
            put(zop[k], {3'h0, ad});
            if (k inside {3, 5, 7}) ex(ad, r8, 1);
            else a = r8;
            cyc++;
            if (!(k inside {3, 5, 7})) st(8'(8'h60 + k));
        end
        cg[2] = exq.size();
        for (k = 0; k < 8; k++) begin
            m = 8'($random(seed));
            ad = 8'(8'h70 + k);
            icy_mem_model_i.dm[ad] = m;
            lt = k[0];
            th = k[1];
            r8 = lt ? {m[6:0], th ? fl[1] : m[7]} : {th ? fl[1] : m[0], m[7:1]};
            if (th) fl[1] = lt ? m[7] : m[0];
            put(k[2] ? icy_pkg::ICY_ROTATE_A : icy_pkg::ICY_ROTATE_M, {1'b0, th, lt, ad});
            if (!k[2]) ex(ad, r8, 1);
            else a = r8;
            cyc++;
            if (k[2]) st(8'(8'h78 + k));
        end
        cg[3] = exq.size();
        m = 8'($random(seed));
        icy_mem_model_i.dm[8'h90] = m;
        for (k = 0; k < 8; k++) begin
            b = 3'(k);
            put(m[b] ? icy_pkg::ICY_BIT_CLEAR : icy_pkg::ICY_BIT_SET, {b, 8'h90});
            m[b] = ~m[b];
            ex(8'h90, m, 1);
            cyc++;
        end
        cg[4] = exq.size();
        put(icy_pkg::ICY_UNCONDITIONAL_BRANCH, 11'(pc));
        tot = exq.size();
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        for (k = 0; k < 5; k++) begin
            wq(tot - cg[k]);
            $display("test %0d done", k);
        end
        repeat (40) @(posedge clk);
        stop_test;
    end
endmodule
`default_nettype wire
